// *** src/gated_sixteen_bit_timer.v ***
`include "gated_timer_defs.vh"

module gated_sixteen_bit_timer (
  input  wire        clock,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ext_clock_pin,
  input  wire        crystal_in_pin,
  input  wire        gate_input_pin,
  input  wire        eight_bit_timer_wrap,
  input  wire        sleep_mode,
  output reg         irq_request,
  output reg         wake_request
);

  // ****************************************************************************
  // Software visible state.
  // ****************************************************************************
  reg  [7:0]  timer_one_control_ff;  // Timer control register.
  reg  [7:0]  gate_control_reg_ff;   // Gate control; status bit is inserted on read.
  reg  [15:0] count_ff;              // The counter byte pair.
  reg         overflow_flag_ff;      // Sticky counter wrap flag.
  reg         gate_event_flag_ff;    // Sticky gate completion flag.
  reg         overflow_irq_enable_ff;   // Overflow interrupt enable.
  reg         gate_event_irq_enable_ff; // Gate event interrupt enable.
  reg  [15:0] read_hold_ff;          // Snapshot of the count that reads return.

  // ****************************************************************************
  // Internal timing state.
  // ****************************************************************************
  reg  [2:0]  ext_sync_ff;    // Three-stage pin synchroniser for the external clock.
  reg  [2:0]  xosc_sync_ff;   // Three-stage synchroniser for the crystal input.
  reg  [2:0]  gpin_sync_ff;   // Three-stage synchroniser for the gate pin.
  reg         ext_level_ff;   // Agreed level of the selected external clock.
  reg         gpin_level_ff;  // Agreed gate pin level.
  reg  [1:0]  instr_div_ff;   // Divider that forms the instruction clock enable.
  reg  [2:0]  prescale_ff;    // Hidden prescale counter.
  reg         gate_src_ff;    // Previous selected gate source level.
  reg         toggle_ff;      // Gate toggle flip-flop.
  reg         gate_val_ff;    // Current gate control value.
  reg         spm_open_ff;    // Single pulse window is open.
  reg  [2:0]  settle_ff;      // Cycles since reset, counted until the pin synchroniser has filled.

  // ****************************************************************************
  // Bus decode.
  // ****************************************************************************
  // Writes commit in the access cycle; reads are latched in the setup cycle.
  wire        bus_wr   = psel & penable & pwrite & pready;
  wire        bus_rd   = psel & ~penable & ~pwrite;
  wire        wr_tc    = bus_wr & (paddr == `ADDR_TIMER_CTRL);
  wire        wr_gc    = bus_wr & (paddr == `ADDR_GATE_CTRL);
  wire        wr_lo    = bus_wr & (paddr == `ADDR_COUNT_LOW);
  wire        wr_hi    = bus_wr & (paddr == `ADDR_COUNT_HIGH);
  wire        wr_fl    = bus_wr & (paddr == `ADDR_FLAGS);
  wire        wr_ie    = bus_wr & (paddr == `ADDR_IRQ_ENABLE);

  // Address is mapped when it names one of the registers.
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `ADDR_TIMER_CTRL) | (a == `ADDR_GATE_CTRL) | (a == `ADDR_COUNT_LOW) |
               (a == `ADDR_COUNT_HIGH) | (a == `ADDR_FLAGS) | (a == `ADDR_IRQ_ENABLE) |
               (a == `ADDR_SLEEP_CTRL);
    end
  endfunction

  // ****************************************************************************
  // Field views.
  // ****************************************************************************
  wire        timer_on_bit          = timer_one_control_ff[`TC_ON_BIT];
  wire        ext_clock_nosync_bit  = timer_one_control_ff[`TC_NOSYNC_BIT];
  wire        crystal_osc_enable    = timer_one_control_ff[`TC_XOSC_BIT];
  wire [1:0]  prescale_select       = timer_one_control_ff[`TC_PS_LSB+1:`TC_PS_LSB];
  wire [1:0]  clock_source_select   = timer_one_control_ff[`TC_CS_LSB+1:`TC_CS_LSB];
  wire [1:0]  gate_source_select    = gate_control_reg_ff[`GC_SS_LSB+1:`GC_SS_LSB];
  wire        pulse_acquire_go      = gate_control_reg_ff[`GC_GO_BIT];
  wire        gate_single_pulse_bit = gate_control_reg_ff[`GC_SPM_BIT];
  wire        gate_toggle_mode_bit  = gate_control_reg_ff[`GC_TM_BIT];
  wire        gate_polarity_bit     = gate_control_reg_ff[`GC_POL_BIT];
  wire        gate_enable_bit       = gate_control_reg_ff[`GC_GE_BIT];
  // Codes 1X name an external input; only then does the sync bit matter.
  wire        is_external           = clock_source_select[1];

  // ****************************************************************************
  // Clock source and prescaler.
  // ****************************************************************************
  // Agreed external level: crystal or pin per oscillator enable.
  wire        ext_agree = crystal_osc_enable ? (xosc_sync_ff[1] == xosc_sync_ff[2])
                                             : (ext_sync_ff[1] == ext_sync_ff[2]);
  wire        ext_new   = crystal_osc_enable ? xosc_sync_ff[2] : ext_sync_ff[2];
  // Rising edge of the external clock seen in the system domain.
  wire        ext_rise  = ext_agree & ext_new & ~ext_level_ff;

  reg         src_tick;  // One-cycle enable at the selected source rate.
  // Source mux; code 11 is reserved and gives no tick.
  always @* begin
    case (clock_source_select)
      `CS_INSTR:    src_tick = (instr_div_ff == `INSTR_DIV);
      `CS_SYSTEM:   src_tick = 1'b1;
      `CS_EXTERNAL: src_tick = ext_rise;
      default:      src_tick = 1'b0;
    endcase
  end

  // Sleep stops internal and synchronised sources, not the unsynchronised external path.
  wire        sleep_ok = ~sleep_mode | (is_external & ext_clock_nosync_bit);

  // Prescaler terminal count for the selected ratio.
  function [2:0] ps_limit;
    input [1:0] sel;
    begin
      ps_limit = (3'h1 << sel) - 3'h1;
    end
  endfunction

  wire        ps_tick = src_tick & sleep_ok & (prescale_ff == ps_limit(prescale_select));

  // ****************************************************************************
  // Gate path.
  // ****************************************************************************
  reg         gate_src;  // Selected gate source; reserved codes read low.
  always @* begin
    case (gate_source_select)
      `GS_PIN:    gate_src = gpin_level_ff;
      `GS_TIMER8: gate_src = eight_bit_timer_wrap;
      default:    gate_src = 1'b0;
    endcase
  end

  // Polarity turns the source into an active-high level before toggling.
  wire        gate_pol   = ~(gate_src ^ gate_polarity_bit);
  wire        gate_pol_q = ~(gate_src_ff ^ gate_polarity_bit);
  // A rising active level is the incrementing edge that toggle and single pulse act on.
  wire        gate_inc   = gate_pol & ~gate_pol_q;
  // Toggle is held clear while its mode is off or the timer is stopped.
  wire        nxt_toggle = (~gate_toggle_mode_bit | ~timer_on_bit) ? 1'b0 :
                           (gate_inc ? ~toggle_ff : toggle_ff);
  wire        gate_mode  = gate_toggle_mode_bit ? nxt_toggle : gate_pol;
  // Previous mode level, so that the window opens on an edge and not on a standing level.
  wire        gate_prev  = gate_toggle_mode_bit ? toggle_ff : gate_pol_q;
  // Single pulse admits only the window opened by go.
  wire        nxt_open   = gate_single_pulse_bit & (spm_open_ff ? gate_mode :
                           (pulse_acquire_go & gate_mode & ~gate_prev));
  // With single pulse on, the gate value is the window itself.
  wire        nxt_gate_val = gate_single_pulse_bit ? nxt_open : gate_mode;
  // The window closing is the trailing edge that clears go.
  wire        spm_done   = spm_open_ff & ~nxt_open;
  // Gate flops wait until the synchronised pin level is real, so reset makes no false edge.
  wire        gate_primed = (settle_ff == `GATE_SETTLE);

  // Counting needs timer on; gate only matters when enabled.
  wire        count_en = timer_on_bit & (~gate_enable_bit | gate_val_ff);
  wire        inc      = count_en & ps_tick;
  wire        wrap     = inc & (count_ff == 16'hFFFF);

  // ****************************************************************************
  // Synchronisers and dividers.
  // ****************************************************************************
  // Pin inputs pass three flops; changes accepted when stages two and three agree.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_sync_ff   <= 3'h0;
      xosc_sync_ff  <= 3'h0;
      gpin_sync_ff  <= 3'h0;
      ext_level_ff  <= 1'b0;
      gpin_level_ff <= 1'b0;
      instr_div_ff  <= 2'h0;
      settle_ff     <= 3'h0;
    end else begin
      ext_sync_ff  <= {ext_sync_ff[1:0], ext_clock_pin};
      xosc_sync_ff <= {xosc_sync_ff[1:0], crystal_in_pin};
      gpin_sync_ff <= {gpin_sync_ff[1:0], gate_input_pin};
      // External level tracks the selected agreed input.
      if (ext_agree) begin
        ext_level_ff <= ext_new;
      end
      if (gpin_sync_ff[1] == gpin_sync_ff[2]) begin
        gpin_level_ff <= gpin_sync_ff[2];
      end
      instr_div_ff <= instr_div_ff + 2'h1;
      // Count the first cycles after reset, then hold.
      if (settle_ff != `GATE_SETTLE) begin
        settle_ff <= settle_ff + 3'h1;
      end
    end
  end

  // ****************************************************************************
  // Prescaler, gate and counter.
  // ****************************************************************************
  // Prescaler resets on any counter byte write.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prescale_ff <= 3'h0;
    end else if (wr_lo | wr_hi) begin
      prescale_ff <= 3'h0;
    end else if (src_tick & sleep_ok) begin
      prescale_ff <= ps_tick ? 3'h0 : prescale_ff + 3'h1;
    end
  end

  // Gate flops follow the source every cycle, even with gating disabled.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      gate_src_ff <= 1'b0;
      toggle_ff   <= 1'b0;
      gate_val_ff <= 1'b0;
      spm_open_ff <= 1'b0;
    end else begin
      gate_src_ff <= gate_src;
      // Before the synchroniser fills, its reset level would look like a gate edge.
      if (gate_primed) begin
        toggle_ff   <= nxt_toggle;
        gate_val_ff <= nxt_gate_val;
        spm_open_ff <= nxt_open;
      end
    end
  end

  // Counter: a byte write replaces one half, otherwise increments when enabled.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count_ff <= 16'h0000;
    end else if (wr_lo) begin
      count_ff <= {count_ff[15:8], pwdata[7:0]};
    end else if (wr_hi) begin
      count_ff <= {pwdata[7:0], count_ff[7:0]};
    end else if (inc) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // ****************************************************************************
  // Control registers and flags.
  // ****************************************************************************
  // Set of a flag wins over a software clear in the same cycle.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_one_control_ff     <= `RESET_BYTE;
      gate_control_reg_ff      <= `RESET_BYTE;
      overflow_flag_ff         <= 1'b0;
      gate_event_flag_ff       <= 1'b0;
      overflow_irq_enable_ff   <= 1'b0;
      gate_event_irq_enable_ff <= 1'b0;
    end else begin
      if (wr_tc) begin
        timer_one_control_ff <= pwdata[7:0] & `TC_WRITE_MASK;
      end
      // Go bit is cleared by hardware when the pulse window closes.
      if (wr_gc) begin
        gate_control_reg_ff <= {pwdata[7:3] & {4'hF, ~spm_done}, 1'b0, pwdata[1:0]};
      end else if (spm_done) begin
        gate_control_reg_ff[`GC_GO_BIT] <= 1'b0;
      end
      if (wr_ie) begin
        overflow_irq_enable_ff   <= pwdata[`FL_OVF_BIT];
        gate_event_irq_enable_ff <= pwdata[`FL_GATE_BIT];
      end
      // Flags are write-one-to-clear.
      // Overflow sets on the wrapping increment itself.
      if (wrap) begin
        overflow_flag_ff <= 1'b1;
      end else if (wr_fl & pwdata[`FL_OVF_BIT]) begin
        overflow_flag_ff <= 1'b0;
      end
      // Gate event sets on the falling edge of the gate value.
      if (gate_val_ff & ~nxt_gate_val) begin
        gate_event_flag_ff <= 1'b1;
      end else if (wr_fl & pwdata[`FL_GATE_BIT]) begin
        gate_event_flag_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************************
  // APB slave and outputs.
  // ****************************************************************************
  // Read data is latched in the setup cycle from a snapshot retaken every cycle, so each byte read is its own sample.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata       <= 32'h00000000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      read_hold_ff <= 16'h0000;
      irq_request  <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      // Every setup cycle is answered in the next cycle, with no wait states.
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      read_hold_ff <= count_ff;
      if (bus_rd) begin
        case (paddr)
          `ADDR_TIMER_CTRL: prdata <= {24'h000000, timer_one_control_ff};
          `ADDR_GATE_CTRL:  prdata <= {24'h000000, gate_control_reg_ff[7:3], gate_val_ff,
                                       gate_control_reg_ff[1:0]};
          `ADDR_COUNT_LOW:  prdata <= {24'h000000, read_hold_ff[7:0]};
          `ADDR_COUNT_HIGH: prdata <= {24'h000000, read_hold_ff[15:8]};
          `ADDR_FLAGS:      prdata <= {24'h000000, gate_event_flag_ff, 6'h00, overflow_flag_ff};
          `ADDR_IRQ_ENABLE: prdata <= {24'h000000, gate_event_irq_enable_ff, 6'h00, overflow_irq_enable_ff};
          `ADDR_SLEEP_CTRL: prdata <= {31'h00000000, sleep_ok};
          default:          prdata <= 32'h00000000;
        endcase
      end
      irq_request  <= (overflow_flag_ff & overflow_irq_enable_ff) |
                      (gate_event_flag_ff & gate_event_irq_enable_ff);
      wake_request <= sleep_mode & overflow_flag_ff & overflow_irq_enable_ff;
    end
  end

endmodule // gated_sixteen_bit_timer

// *** src/gated_timer_defs.vh ***
`ifndef GATED_TIMER_DEFS_VH
`define GATED_TIMER_DEFS_VH
// ****************************************************************************
// Register map, byte addresses on the APB.
// ****************************************************************************
`define ADDR_TIMER_CTRL    12'h000
`define ADDR_GATE_CTRL     12'h004
`define ADDR_COUNT_LOW     12'h008
`define ADDR_COUNT_HIGH    12'h00C
`define ADDR_FLAGS         12'h010
`define ADDR_IRQ_ENABLE    12'h014
`define ADDR_SLEEP_CTRL    12'h018
// ****************************************************************************
// Timer control field positions.
// ****************************************************************************
`define TC_ON_BIT          0
`define TC_NOSYNC_BIT      2
`define TC_XOSC_BIT        3
`define TC_PS_LSB          4
`define TC_CS_LSB          6
`define TC_WRITE_MASK      8'hFD
// ****************************************************************************
// Gate control field positions.
// ****************************************************************************
`define GC_SS_LSB          0
`define GC_VAL_BIT         2
`define GC_GO_BIT          3
`define GC_SPM_BIT         4
`define GC_TM_BIT          5
`define GC_POL_BIT         6
`define GC_GE_BIT          7
// ****************************************************************************
// Flag bits, shared by the flag and enable registers.
// ****************************************************************************
`define FL_OVF_BIT         0
`define FL_GATE_BIT        7
// ****************************************************************************
// Selector codes and reset values.
// ****************************************************************************
`define CS_INSTR           2'h0
`define CS_SYSTEM          2'h1
`define CS_EXTERNAL        2'h2
`define GS_PIN             2'h0
`define GS_TIMER8          2'h1
`define INSTR_DIV          2'h3
`define GATE_SETTLE        3'h5
`define RESET_BYTE         8'h00
`endif

// *** tb/gated_timer_assertions.sv ***
// ****************************************************************************
// Port checker for the gated timer.
// ****************************************************************************
module gated_timer_checker (
  input wire        clock,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        ext_clock_pin,
  input wire        crystal_in_pin,
  input wire        gate_input_pin,
  input wire        eight_bit_timer_wrap,
  input wire        sleep_mode,
  input wire        irq_request,
  input wire        wake_request
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks share the one system clock and its reset.
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_ready_in_access : assert property (
    psel && !penable |=> pready) else $error("No answer in the access cycle.");
  a_ready_from_setup : assert property (
    pready |-> $past(psel && !penable)) else $error("Answer without a setup cycle.");
  a_err_with_ready : assert property (
    pslverr |-> pready) else $error("Error flag outside an answer.");
  a_unmapped_error : assert property (
    psel && !penable && paddr > 12'h018 |=> pslverr) else $error("Unmapped access not refused.");
  a_unmapped_zero : assert property (
    pslverr && !$past(pwrite) |-> prdata == 32'h0) else $error("Refused read returned data.");
  a_read_data_hold : assert property (
    $changed(prdata) |-> $past(psel && !penable && !pwrite)) else $error("Read data moved without a read.");
  a_wake_in_sleep : assert property (
    wake_request |-> $past(sleep_mode)) else $error("Wake raised while awake.");
  a_wake_has_irq : assert property (
    wake_request |-> irq_request) else $error("Wake without an overflow request.");
  a_flag_sticky : assert property (
    $fell(irq_request) |-> $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
    else $error("Request dropped without a write.");
endmodule // gated_timer_checker

bind gated_sixteen_bit_timer gated_timer_checker gated_timer_checker_i (.clock(clock), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_clock_pin(ext_clock_pin), .crystal_in_pin(crystal_in_pin),
  .gate_input_pin(gate_input_pin), .eight_bit_timer_wrap(eight_bit_timer_wrap), .sleep_mode(sleep_mode),
  .irq_request(irq_request), .wake_request(wake_request));

// *** tb/pin_side_model.sv ***
// ****************************************************************************
// Pin side: external clock, crystal square wave and eight-bit timer wrap.
// ****************************************************************************
module pin_side_model (
  input  wire logic clock,
  input  wire logic rst,
  output logic      ext_clock_pin,
  output logic      crystal_in_pin,
  output logic      eight_bit_timer_wrap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_ff; // Divider for an eight-cycle pin clock.
  logic [7:0] t8_ff;  // Free running eight-bit timer.
  // Both clocks run free; the timer pulses once per wrap.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      div_ff <= 2'h0;
      t8_ff <= 8'h00;
      ext_clock_pin <= 1'b0;
      crystal_in_pin <= 1'b0;
      eight_bit_timer_wrap <= 1'b0;
    end else begin
      div_ff <= div_ff + 2'h1;
      t8_ff <= t8_ff + 8'h01;
      if (div_ff == 2'h3) begin
        ext_clock_pin <= ~ext_clock_pin;
        crystal_in_pin <= ~crystal_in_pin;
      end
      eight_bit_timer_wrap <= (t8_ff == 8'hFF);
    end
  end
endmodule // pin_side_model

// *** tb/testbench.sv ***
`include "gated_timer_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_t;
  logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        sleep_mode = 1'b0, gate_input_pin = 1'b1, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [15:0] cnt, c1;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq_request, wake_request, ext_clock_pin, crystal_in_pin, eight_bit_timer_wrap;
  int          miscompares = 0, cmp_count = 0, cyc = 0, ex;
  int          divs [4] = '{4, 1, 8, 0};
  // Register rows: address, write value, read back, refused.
  row_t rows [0:9] = '{'{12'h000, 32'hFE, 32'hFC, 1'b0}, '{12'h000, 32'h0, 32'h0, 1'b0},
    '{12'h004, 32'hC1, 32'hC1, 1'b0}, '{12'h004, 32'h0, 32'h0, 1'b0}, '{12'h008, 32'h5A, 32'h5A, 1'b0},
    '{12'h00C, 32'hA5, 32'hA5, 1'b0}, '{12'h014, 32'h81, 32'h81, 1'b0}, '{12'h014, 32'h0, 32'h0, 1'b0},
    '{12'h010, 32'hFF, 32'h0, 1'b0}, '{12'h020, 32'h55, 32'h0, 1'b1}};
  gated_sixteen_bit_timer gated_sixteen_bit_timer_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_pin(ext_clock_pin), .crystal_in_pin(crystal_in_pin), .gate_input_pin(gate_input_pin),
    .eight_bit_timer_wrap(eight_bit_timer_wrap), .sleep_mode(sleep_mode), .irq_request(irq_request),
    .wake_request(wake_request));
  pin_side_model pin_side_model_i (.clock(clock), .rst(rst), .ext_clock_pin(ext_clock_pin),
    .crystal_in_pin(crystal_in_pin), .eight_bit_timer_wrap(eight_bit_timer_wrap));
  // ****************************************************************************
  // Clock, timeout and shared tasks.
  // ****************************************************************************
  always #2 clock = ~clock;
  // Cuts a hung run short.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out;
    end
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] w);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Compares a word.
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Compares a count against a window.
  task automatic check_rng(input logic [15:0] g, input int lo, input int hi);
    cmp_count++;
    if ($isunknown(g) || g < lo || g > hi) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, g, lo, hi);
    end
  endtask
  // Stops the timer, then reads both counter bytes.
  task automatic stop_read;
    xfer(1'b1, `ADDR_TIMER_CTRL, 32'h0);
    xfer(1'b0, `ADDR_COUNT_LOW, 32'h0);
    cnt[7:0] = rd[7:0];
    xfer(1'b0, `ADDR_COUNT_HIGH, 32'h0);
    cnt[15:8] = rd[7:0];
  endtask
  // Clears the counter, sets gate control, starts on the system clock.
  task automatic start_gated(input logic [31:0] gc);
    xfer(1'b1, `ADDR_COUNT_LOW, 32'h0);
    xfer(1'b1, `ADDR_COUNT_HIGH, 32'h0);
    xfer(1'b1, `ADDR_GATE_CTRL, gc);
    xfer(1'b1, `ADDR_FLAGS, 32'hFF);
    xfer(1'b1, `ADDR_TIMER_CTRL, 32'h41);
  endtask
  // ****************************************************************************
  // Main sequence.
  // ****************************************************************************
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, 12'(i * 4), 32'h0);
      check_val(rd, 32'h0);
    end
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].a, rows[i].w);
      check_val({31'h0, er}, {31'h0, rows[i].e});
      xfer(1'b0, rows[i].a, 32'h0);
      check_val(rd, rows[i].r);
      check_val({31'h0, er}, {31'h0, rows[i].e});
    end
    $display("test registers done");
    for (int cs = 0; cs < 4; cs++) begin
      for (int ps = 0; ps < 4; ps++) begin
        xfer(1'b1, `ADDR_COUNT_LOW, 32'h0);
        xfer(1'b1, `ADDR_COUNT_HIGH, 32'h0);
        xfer(1'b1, `ADDR_TIMER_CTRL, 32'(cs * 64 + ps * 16 + 1));
        repeat (256) @(posedge clock);
        stop_read;
        ex = (divs[cs] == 0) ? 0 : 259 / (divs[cs] << ps);
        check_rng(cnt, (ex > 3) ? ex - 3 : 0, (divs[cs] == 0) ? 0 : ex + 3);
      end
    end
    $display("test clock sources done");
    gate_input_pin <= 1'b0;
    start_gated(32'hC0);
    repeat (100) @(posedge clock);
    xfer(1'b0, `ADDR_GATE_CTRL, 32'h0);
    check_val(rd, 32'hC0);
    gate_input_pin <= 1'b1;
    repeat (50) @(posedge clock);
    xfer(1'b0, `ADDR_GATE_CTRL, 32'h0);
    check_val(rd, 32'hC4);
    repeat (47) @(posedge clock);
    gate_input_pin <= 1'b0;
    repeat (60) @(posedge clock);
    stop_read;
    check_rng(cnt, 98, 106);
    xfer(1'b0, `ADDR_FLAGS, 32'h0);
    check_val(rd, 32'h80);
    xfer(1'b1, `ADDR_IRQ_ENABLE, 32'h80);
    repeat (3) @(posedge clock);
    check_val({31'h0, irq_request}, 32'h1);
    xfer(1'b1, `ADDR_FLAGS, 32'h80);
    repeat (3) @(posedge clock);
    check_val({31'h0, irq_request}, 32'h0);
    $display("test gate level done");
    start_gated(32'hD8);
    for (int p = 0; p < 2; p++) begin
      gate_input_pin <= 1'b1;
      repeat (40) @(posedge clock);
      gate_input_pin <= 1'b0;
      repeat (10) @(posedge clock);
    end
    xfer(1'b0, `ADDR_GATE_CTRL, 32'h0);
    check_val(rd, 32'hD0);
    stop_read;
    check_rng(cnt, 38, 43);
    xfer(1'b1, `ADDR_GATE_CTRL, 32'hC0);
    $display("test single pulse done");
    start_gated(32'hE1);
    repeat (508) @(posedge clock);
    stop_read;
    check_rng(cnt, 250, 262);
    xfer(1'b1, `ADDR_GATE_CTRL, 32'h0);
    $display("test toggle done");
    start_gated(32'hF9);
    repeat (600) @(posedge clock);
    xfer(1'b0, `ADDR_GATE_CTRL, 32'h0);
    check_val(rd, 32'hF1);
    stop_read;
    check_rng(cnt, 253, 259);
    xfer(1'b1, `ADDR_GATE_CTRL, 32'h0);
    $display("test toggle single pulse done");
    xfer(1'b1, `ADDR_COUNT_LOW, 32'hF0);
    xfer(1'b1, `ADDR_COUNT_HIGH, 32'hFF);
    xfer(1'b1, `ADDR_FLAGS, 32'hFF);
    xfer(1'b1, `ADDR_IRQ_ENABLE, 32'h01);
    sleep_mode <= 1'b1;
    xfer(1'b1, `ADDR_TIMER_CTRL, 32'h85);
    repeat (200) @(posedge clock);
    check_val({30'h0, wake_request, irq_request}, 32'h3);
    sleep_mode <= 1'b0;
    xfer(1'b0, `ADDR_FLAGS, 32'h0);
    check_val(rd, 32'h01);
    xfer(1'b1, `ADDR_FLAGS, 32'h01);
    repeat (3) @(posedge clock);
    check_val({30'h0, wake_request, irq_request}, 32'h0);
    $display("test overflow done");
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    xfer(1'b0, `ADDR_TIMER_CTRL, 32'h0);
    check_val(rd, 32'h0);
    xfer(1'b0, `ADDR_FLAGS, 32'h0);
    check_val(rd, 32'h0);
    check_val({30'h0, wake_request, irq_request}, 32'h0);
    xfer(1'b0, `ADDR_GATE_CTRL, 32'h0);
    check_val(rd, 32'h04);
    $display("test reset done");
    close_out;
  end
endmodule // testbench
